// ==== rtl/link_vec_pkg.sv ====
// Behaviour
// RQ1: vector reports highest pending source as code 0..8, register value is code times four.
// RQ2: clearing a higher source immediately exposes the remaining lower source code.
// RQ3: vector read clears the reported source, except data-service sources.
// RQ4: receive-full and response-byte flags clear on vector read then data read.
// RQ5: transmit-empty clears on vector read then data write, or end-of-data request.
// RQ6: software writes each later transmit byte only after transmit-empty is reported.
// RQ7: data read returns last received byte from the receive shadow register.
// RQ8: finished shift register reloads from the transmit shadow register.
// RQ9: transmit-empty sets after first bit of a loaded byte; shadow then accepts.
// RQ10: completed reception copies shift byte to receive shadow and sets receive-full.
// RQ11: next complete byte overwrites receive shadow; software has one byte time.
// RQ12: missing byte is underrun; transmitter stops after byte plus two ones.
// RQ13: underrun abort is reported in the vector as invalid symbol.
// RQ14: wait with wait-clock-stop clear enters wait mode; bus not driven.
// RQ15: wait mode keeps receiving; good message wakes and interrupts if enabled.
// RQ16: stop instruction, or wait with wait-clock-stop set, enters stop mode.
// RQ17: in stop mode a passive-to-active bus edge wakes and raises non-maskable request.
// RQ18: waking byte guaranteed only if stop came via wait after end of frame.
// RQ19: stop during reception: first edge wakes, interrupts, waits for clock settle.
// RQ20: software completes or aborts transmission before wait or stop.
// RQ21: end-of-data during response with CRC sends CRC then end-of-data symbol.
// RQ22: vector bits outside code read zero; writes to it do nothing.
package link_vec_pkg;
  localparam logic [7:0] VEC_OFS = 8'h00;
  localparam logic [7:0] DATA_OFS = 8'h04;
  localparam logic [7:0] CTL1_OFS = 8'h08;
  localparam logic [7:0] CTL2_OFS = 8'h0C;
  localparam int IE_BIT = 0;
  localparam int WCS_BIT = 1;
  localparam int EOD_BIT = 0;
  localparam int CRC_BIT = 1;
  localparam logic [3:0] SRC_NONE = 4'h0;
  localparam logic [3:0] SRC_EOF = 4'h1;
  localparam logic [3:0] SRC_RESPONSE_BYTE_RECEIVED_FLAG = 4'h2;
  localparam logic [3:0] SRC_RX_BUFFER_FULL_FLAG = 4'h3;
  localparam logic [3:0] SRC_TX_BUFFER_EMPTY_FLAG = 4'h4;
  localparam logic [3:0] SRC_ARB = 4'h5;
  localparam logic [3:0] SRC_CRC = 4'h6;
  localparam logic [3:0] SRC_INV = 4'h7;
  localparam logic [3:0] SRC_WAKE = 4'h8;
  localparam int SETTLE_NS = 1000;
  localparam int CLK_NS = 10;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {
    PM_RUN = 2'b00,
    PM_WAIT = 2'b01,
    PM_STOP = 2'b10,
    PM_SETTLE = 2'b11
  } pmode_type;
endpackage : link_vec_pkg

// ==== rtl/link_vec.sv ====
`timescale 1ns/1ns
module link_vec (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // events from the protocol engine
  input wire logic eof_seen,
  input wire logic ifr_byte,
  input wire logic rx_byte_done,
  input wire logic [7:0] rx_shift,
  input wire logic arb_lost,
  input wire logic crc_error,
  input wire logic symbol_invalid,
  input wire logic rx_busy,
  input wire logic bus_active,
  // transmit bit stream
  input wire logic tx_bit_taken,
  output logic tx_bit,
  output logic tx_active,
  output logic tx_send_crc,
  output logic tx_send_eod,
  output logic tx_abort,
  output logic bus_drive_en,
  // power management
  input wire logic cpu_wait,
  input wire logic cpu_stop,
  output logic clocks_run,
  output logic rx_guaranteed,
  output logic irq_request,
  output logic nmi_request
);
  import link_vec_pkg::*;

  logic eof_q, response_byte_received_flag_q, rx_buffer_full_flag_q, tx_buffer_empty_flag_q, arb_q, crc_q, inv_q, wake_q;
  logic [7:0] rxsh_q, txsh_q, shift_q;
  logic txfull_q, armed_q, ie_q, wcs_q, eod_q, crcmode_q;
  logic [3:0] bits_q;
  logic [1:0] ones_q;
  logic first_q, act_q, crc_q2, eod_q2, abort_q, nmi_q, eofpre_q, bus_q;
  logic [15:0] settle_q;
  pmode_type pm_q;
  logic wake_evt;

  // bus decode
  wire acc = psel & penable;
  wire rd = acc & ~pwrite;
  wire wr = acc & pwrite;
  wire hit_vec = paddr == VEC_OFS;
  wire hit_data = paddr == DATA_OFS;
  wire hit_c1 = paddr == CTL1_OFS;
  wire hit_c2 = paddr == CTL2_OFS;
  wire mapped = hit_vec | hit_data | hit_c1 | hit_c2;
  wire vec_rd = rd & hit_vec;
  wire data_rd = rd & hit_data;
  wire data_wr = wr & hit_data;
  wire eod_set = wr & hit_c2 & pwdata[EOD_BIT];

  // RQ1: priority encode
  logic [3:0] code;
  always_comb begin
    code = SRC_NONE;
    if (wake_q) code = SRC_WAKE;
    else if (inv_q) code = SRC_INV;
    else if (crc_q) code = SRC_CRC;
    else if (arb_q) code = SRC_ARB;
    else if (tx_buffer_empty_flag_q) code = SRC_TX_BUFFER_EMPTY_FLAG;
    else if (rx_buffer_full_flag_q) code = SRC_RX_BUFFER_FULL_FLAG;
    else if (response_byte_received_flag_q) code = SRC_RESPONSE_BYTE_RECEIVED_FLAG;
    else if (eof_q) code = SRC_EOF;
  end

  // RQ3: vector read clears the reported source unless it is a data-service source
  wire svc = code == SRC_TX_BUFFER_EMPTY_FLAG || code == SRC_RX_BUFFER_FULL_FLAG || code == SRC_RESPONSE_BYTE_RECEIVED_FLAG;
  wire clr_plain = vec_rd & ~svc;
  // RQ4: data read after the vector read clears the reported receive flag
  wire clr_rx = data_rd & armed_q;
  // RQ5: data write after the vector read, or end-of-data, clears empty
  wire clr_tx_buffer_empty_flag = (data_wr & armed_q & code == SRC_TX_BUFFER_EMPTY_FLAG) | eod_set;

  // RQ22: code sits in bits 5:2, rest zero
  wire [31:0] vec_word = {26'h0, code, 2'h0};
  wire [31:0] c1_word = {30'h0, wcs_q, ie_q};
  wire [31:0] c2_word = {30'h0, crcmode_q, eod_q};
  // RQ7: data reads return the receive shadow
  assign prdata = !rd ? 32'h0 : hit_vec ? vec_word : hit_data ? {24'h0, rxsh_q}
                : hit_c1 ? c1_word : hit_c2 ? c2_word : 32'h0;
  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  // transmit bit strobes only count while actually shifting
  wire bit_tick = act_q & tx_bit_taken;
  wire byte_end = bit_tick & bits_q == 4'h7 & ones_q == 2'h0;
  wire load_now = ~act_q & txfull_q & pm_q == PM_RUN;
  wire reload = byte_end & txfull_q;
  // RQ12: byte boundary with nothing queued and no end request
  wire underrun = byte_end & ~txfull_q & ~eod_q;
  wire tail_end = bit_tick & ones_q == 2'h1;
  wire normal_end = byte_end & ~txfull_q & eod_q;
  // RQ13: underrun abort shows as invalid symbol
  wire inv_evt = symbol_invalid | tail_end;
  // RQ9: first bit of a freshly loaded byte has gone out
  wire tx_buffer_empty_flag_evt = bit_tick & first_q;

  // RQ2: flags, set wins over clear so code tracks remaining sources
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eof_q <= 1'b0;
      arb_q <= 1'b0;
      crc_q <= 1'b0;
      inv_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      eof_q <= eof_seen | (eof_q & ~(clr_plain & code == SRC_EOF));
      arb_q <= arb_lost | (arb_q & ~(clr_plain & code == SRC_ARB));
      crc_q <= crc_error | (crc_q & ~(clr_plain & code == SRC_CRC));
      inv_q <= inv_evt | (inv_q & ~(clr_plain & code == SRC_INV));
      wake_q <= wake_evt | (wake_q & ~(clr_plain & code == SRC_WAKE));
    end
  end

  // RQ10: completed byte to shadow, full flag set (response-byte flag for a response byte)
  // RQ11: the next byte overwrites the shadow unconditionally
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxsh_q <= 8'h00;
      rx_buffer_full_flag_q <= 1'b0;
      response_byte_received_flag_q <= 1'b0;
    end else begin
      if (rx_byte_done) rxsh_q <= rx_shift;
      rx_buffer_full_flag_q <= (rx_byte_done & ~ifr_byte) | (rx_buffer_full_flag_q & ~(clr_rx & code == SRC_RX_BUFFER_FULL_FLAG));
      response_byte_received_flag_q <= (rx_byte_done & ifr_byte) | (response_byte_received_flag_q & ~(clr_rx & code == SRC_RESPONSE_BYTE_RECEIVED_FLAG));
    end
  end

  // vector read arms the data-register access only for a data-service code; any data access disarms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) armed_q <= 1'b0;
    else if (vec_rd) armed_q <= svc;
    else if (data_rd | data_wr) armed_q <= 1'b0;
  end

  // RQ5: empty flag; a new first-bit event wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_buffer_empty_flag_q <= 1'b0;
    else tx_buffer_empty_flag_q <= tx_buffer_empty_flag_evt | (tx_buffer_empty_flag_q & ~clr_tx_buffer_empty_flag);
  end

  // control registers; end-of-data self-clears when the frame closes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_q <= 1'b0;
      wcs_q <= 1'b0;
      eod_q <= 1'b0;
      crcmode_q <= 1'b0;
    end else begin
      if (wr & hit_c1) begin
        ie_q <= pwdata[IE_BIT];
        wcs_q <= pwdata[WCS_BIT];
      end
      if (wr & hit_c2) crcmode_q <= pwdata[CRC_BIT];
      if (eod_set) eod_q <= 1'b1;
      else if (normal_end | tail_end) eod_q <= 1'b0;
    end
  end

  // RQ6: a write only lands in the shadow; software paces itself on empty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txsh_q <= 8'h00;
      txfull_q <= 1'b0;
    end else begin
      if (data_wr) txsh_q <= pwdata[7:0];
      if (data_wr) txfull_q <= 1'b1;
      else if (load_now | reload) txfull_q <= 1'b0;
    end
  end

  // RQ8: shifter reloads from the shadow at a byte end when a byte is queued
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= 8'h00;
      bits_q <= 4'h0;
      first_q <= 1'b0;
      act_q <= 1'b0;
      ones_q <= 2'h0;
    end else if (load_now | reload) begin
      shift_q <= txsh_q;
      bits_q <= 4'h0;
      first_q <= 1'b1;
      act_q <= 1'b1;
    end else if (underrun) begin
      // RQ12: two logic ones follow, then the transmitter stops
      ones_q <= 2'h2;
      shift_q <= 8'hFF;
    end else if (tail_end | normal_end | (act_q & pm_q != PM_RUN)) begin
      act_q <= 1'b0;
      ones_q <= 2'h0;
    end else if (bit_tick) begin
      shift_q <= {shift_q[6:0], 1'b1};
      first_q <= 1'b0;
      if (ones_q != 2'h0) ones_q <= ones_q - 2'h1;
      else bits_q <= bits_q + 4'h1;
    end
  end

  // RQ21: closing requests to the engine, one-cycle pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_q2 <= 1'b0;
      eod_q2 <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      crc_q2 <= normal_end & crcmode_q;
      eod_q2 <= normal_end;
      abort_q <= tail_end;
    end
  end
  assign tx_bit = shift_q[7];
  assign tx_active = act_q;
  assign tx_send_crc = crc_q2;
  assign tx_send_eod = eod_q2;
  assign tx_abort = abort_q;

  // low-power entry and wake decode
  wire enter_wait = pm_q == PM_RUN & cpu_wait & ~wcs_q;
  wire enter_stop = pm_q == PM_RUN & (cpu_stop | (cpu_wait & wcs_q));
  wire bus_rise = bus_active & ~bus_q;
  // RQ15: a good message in wait mode
  wire wait_wake = pm_q == PM_WAIT & eof_seen;
  // RQ17: passive-to-active edge in stop mode
  wire stop_wake = pm_q == PM_STOP & bus_rise;
  assign wake_evt = stop_wake | (wait_wake & ie_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bus_q <= 1'b0;
    else bus_q <= bus_active;
  end

  // end of frame seen since last traffic, sampled for stop entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) eofpre_q <= 1'b0;
    else if (eof_seen) eofpre_q <= 1'b1;
    else if (rx_busy) eofpre_q <= 1'b0;
  end

  // RQ14: wait mode; RQ16: stop mode; RQ19: settle before resuming
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_q <= PM_RUN;
      settle_q <= 16'h0000;
      rx_guaranteed <= 1'b1;
    end else begin
      unique case (pm_q)
        PM_RUN: begin
          if (enter_stop) begin
            pm_q <= PM_STOP;
            // RQ18: only a wait entry after end of frame keeps the byte
            rx_guaranteed <= cpu_wait & ~cpu_stop & eofpre_q & ~rx_busy;
          end else if (enter_wait) begin
            pm_q <= PM_WAIT;
          end
        end
        PM_WAIT: begin
          if (wait_wake | ~cpu_wait) pm_q <= PM_RUN;
        end
        PM_STOP: begin
          if (stop_wake) begin
            pm_q <= PM_SETTLE;
            settle_q <= 16'(SETTLE_CYC - 1);
          end
        end
        PM_SETTLE: begin
          if (settle_q == 16'h0000) begin
            pm_q <= PM_RUN;
            rx_guaranteed <= 1'b1;
          end else begin
            settle_q <= settle_q - 16'h0001;
          end
        end
      endcase
    end
  end

  // non-maskable request is a one-cycle pulse on the stop wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) nmi_q <= 1'b0;
    else nmi_q <= stop_wake;
  end
  assign nmi_request = nmi_q;
  // RQ15: maskable request while any source pends
  assign irq_request = ie_q & (code != SRC_NONE);
  assign clocks_run = pm_q != PM_STOP & pm_q != PM_SETTLE;
  // RQ14: never drive the bus outside run mode
  assign bus_drive_en = act_q & pm_q == PM_RUN;

  a_vec_value: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    wake_q |-> vec_word == 32'h20) else $error("wakeup must read as 20 hex");
  a_vec_lower: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    (code == SRC_ARB && vec_rd && !arb_lost && crc_q == 1'b0 && !crc_error && !wake_evt
     && !inv_evt && tx_buffer_empty_flag_q) |=> code == SRC_TX_BUFFER_EMPTY_FLAG) else $error("lower source not shown");
  a_vec_clear: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    (vec_rd && code == SRC_EOF && !eof_seen) |=> !eof_q) else $error("eof not cleared");
  a_rx_buffer_full_flag_hold: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    (rx_buffer_full_flag_q && !(data_rd && armed_q)) |=> rx_buffer_full_flag_q) else $error("rx_buffer_full_flag lost early");
  a_tx_buffer_empty_flag_clear: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
    (eod_set && !tx_buffer_empty_flag_evt) |=> !tx_buffer_empty_flag_q) else $error("tx_buffer_empty_flag kept after end request");
  a_rx_copy: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
    rx_byte_done |=> rxsh_q == $past(rx_shift) && (rx_buffer_full_flag_q || response_byte_received_flag_q))
    else $error("rx byte not copied");
  a_tx_buffer_empty_flag_first: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    $rose(act_q) ##1 (!tx_bit_taken)[*3] ##1 tx_bit_taken |=> tx_buffer_empty_flag_q)
    else $error("tx_buffer_empty_flag not set after first bit");
  a_under_inv: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
    tail_end |=> inv_q && tx_abort) else $error("underrun not reported");
  a_wait_drive: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
    pm_q == PM_WAIT |-> !bus_drive_en) else $error("bus driven in wait");
  a_stop_nmi: assert property (@(posedge pclk) disable iff (!presetn) // RQ17
    stop_wake |=> nmi_request && pm_q == PM_SETTLE) else $error("stop wake missed");
  // data path and power checks beyond the flag logic
  a_tx_reload: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
    reload |=> tx_active && tx_bit == $past(txsh_q[7]))
    else $error("shadow byte not loaded");
  a_under_ones: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
    underrun |=> tx_active && tx_bit)
    else $error("underrun tail not ones");
  a_wait_wake: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
    (pm_q == PM_WAIT && eof_seen && ie_q) |=> wake_q && pm_q == PM_RUN)
    else $error("wait mode did not wake");
  a_stop_entry: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
    (pm_q == PM_RUN && cpu_stop) |=> pm_q == PM_STOP)
    else $error("stop mode not entered");
  a_settle_hold: assert property (@(posedge pclk) disable iff (!presetn) // RQ19
    stop_wake |=> (!clocks_run && !bus_drive_en)[*8])
    else $error("resumed before clocks settled");
  a_close_crc: assert property (@(posedge pclk) disable iff (!presetn) // RQ21
    (normal_end && crcmode_q) |=> tx_send_crc && tx_send_eod && !tx_active)
    else $error("crc close not requested");
endmodule : link_vec

// ==== verification/bus_node_model.sv ====
`timescale 1ns/1ns
module bus_node_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // transmit side of the block
  input wire logic tx_bit,
  input wire logic tx_active,
  input wire logic tx_send_crc,
  input wire logic tx_send_eod,
  // remote byte request
  input wire logic rx_go,
  input wire logic [7:0] rx_val,
  input wire logic rx_ifr,
  // towards the block
  output logic tx_bit_taken,
  output logic rx_byte_done,
  output logic [7:0] rx_shift,
  output logic ifr_byte,
  output logic rx_busy,
  output logic bus_active,
  // observation
  output logic [31:0] got_q,
  output int nbits,
  output int nclose
);
  logic [1:0] div_q;
  logic [3:0] rcnt_q;
  logic [7:0] last_q;
  // the bus is active only while a remote byte is on the wire
  assign bus_active = rx_busy;
  // outside the done pulse the byte lines carry the inverse, never a stale copy
  assign rx_shift = rx_byte_done ? last_q : ~last_q;
  // one bit taken every fourth cycle: slow enough to service the vector between bits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_bit_taken <= 1'b0;
      div_q <= 2'd0;
      got_q <= 32'h0;
      nbits <= 0;
      nclose <= 0;
    end else begin
      tx_bit_taken <= 1'b0;
      if (tx_bit_taken) begin
        got_q <= {got_q[30:0], tx_bit};
        nbits <= nbits + 1;
      end
      div_q <= tx_active ? div_q + 2'd1 : 2'd0;
      if (tx_active && div_q == 2'd3) begin
        tx_bit_taken <= 1'b1;
      end
      nclose <= nclose + int'(tx_send_crc) + int'(tx_send_eod);
    end
  end
  // one byte time
  // each remote byte occupies ten cycles before it completes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_busy <= 1'b0;
      rx_byte_done <= 1'b0;
      rcnt_q <= 4'h0;
      last_q <= 8'h00;
      ifr_byte <= 1'b0;
    end else begin
      rx_byte_done <= 1'b0;
      if (rx_go) begin
        rx_busy <= 1'b1;
        rcnt_q <= 4'h0;
        last_q <= rx_val;
        ifr_byte <= rx_ifr;
      end else if (rx_busy) begin
        rcnt_q <= rcnt_q + 4'h1;
        if (rcnt_q == 4'h9) begin
          rx_byte_done <= 1'b1;
          rx_busy <= 1'b0;
        end
      end
    end
  end
endmodule : bus_node_model

// ==== verification/link_vec_tb.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin \
  n_checks++; \
  if ((a) !== (b)) begin \
    num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); \
  end \
end
`define WAITC(c) begin \
  wk = 0; \
  while (!(c) && wk < 400) begin \
    @(posedge pclk); \
    wk++; \
  end \
  if (!(c)) fail_out(); \
end
module link_vec_tb;
  import link_vec_pkg::*;
  typedef struct {logic [31:0] e; logic [31:0] m; logic err;} note_type;
  note_type notes[$];
  note_type nt;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_go, rx_ifr;
  logic [7:0] paddr, rx_val, rx_shift, ta, tb2;
  logic [31:0] pwdata, prdata, rs, got;
  logic [3:0] ev;
  logic [3:0] codes[4] = '{SRC_EOF, SRC_ARB, SRC_CRC, SRC_INV};
  logic tx_bit_taken, rx_byte_done, ifr_byte, rx_busy, bus_active, tx_bit, tx_active;
  logic tx_send_crc, tx_send_eod, tx_abort, bus_drive_en, cpu_wait, cpu_stop;
  logic clocks_run, rx_guaranteed, irq_request, nmi_request;
  int num_errors = 0;
  int n_checks = 0;
  int nbits, nclose, wk, n0, nc0;
  link_vec link_vec_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .eof_seen(ev[0]), .ifr_byte, .rx_byte_done, .rx_shift,
    .arb_lost(ev[1]), .crc_error(ev[2]), .symbol_invalid(ev[3]), .rx_busy, .bus_active,
    .tx_bit_taken, .tx_bit, .tx_active, .tx_send_crc, .tx_send_eod, .tx_abort,
    .bus_drive_en, .cpu_wait, .cpu_stop, .clocks_run, .rx_guaranteed, .irq_request,
    .nmi_request);
  bus_node_model bus_node_model_inst (.pclk, .presetn, .tx_bit, .tx_active, .tx_send_crc,
    .tx_send_eod, .rx_go, .rx_val, .rx_ifr, .tx_bit_taken, .rx_byte_done, .rx_shift,
    .ifr_byte, .rx_busy, .bus_active, .got_q(got), .nbits, .nclose);
  task automatic tally_and_finish();
    if (num_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic fail_out();
    num_errors++;
    tally_and_finish();
  endtask : fail_out
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // one apb transfer; the expectation is queued before the request goes out
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m, input logic err);
    notes.push_back('{e, m, err});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    `WAITC(pready === 1'b1)
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rv(input logic [3:0] c);
    apb(1'b0, VEC_OFS, 32'h0, {26'h0, c, 2'b00}, 32'hFFFFFFFF, 1'b0);
  endtask : rv
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask : wr
  task automatic pulse(input logic [3:0] v);
    ev <= v;
    @(posedge pclk);
    ev <= 4'h0;
    @(posedge pclk);
  endtask : pulse
  task automatic rxs(input logic [7:0] v, input logic f);
    rx_val <= v;
    rx_ifr <= f;
    rx_go <= 1'b1;
    @(posedge pclk);
    rx_go <= 1'b0;
    @(posedge pclk);
  endtask : rxs
  task automatic rxb(input logic [7:0] v, input logic f);
    rxs(v, f);
    `WAITC(rx_byte_done === 1'b1)
    @(posedge pclk);
  endtask : rxb
  // completed transfers are compared against the oldest queued note
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      nt = notes.pop_front();
      `CHK(prdata & nt.m, nt.e & nt.m)
      `CHK(pslverr, nt.err)
    end
  end
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    fail_out();
  end
  initial begin
    {presetn, psel, penable, pwrite, rx_go, rx_ifr, cpu_wait, cpu_stop} = 8'h00;
    {paddr, pwdata, rx_val, ev} = 52'h0;
    rs = 32'h659D;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rv(SRC_NONE);
    wr(VEC_OFS, 32'hFFFFFFFF);
    rv(SRC_NONE);
    apb(1'b0, 8'h10, 32'h0, 32'h0, 32'h0, 1'b1);
    // each event alone, then all at once to walk the priority order
    for (int i = 0; i < 4; i++) begin
      pulse(4'h1 << i);
      rv(codes[i]);
      rv(SRC_NONE);
    end
    pulse(4'hF);
    for (int i = 3; i >= 0; i--) begin
      rv(codes[i]);
    end
    rv(SRC_NONE);
    // received bytes: each pass lets a second byte overwrite the shadow, the second pass with response bytes
    for (int i = 0; i < 2; i++) begin
      rs = xs(rs);
      rxb(rs[15:8], i[0]);
      rxb(rs[7:0], i[0]);
      rv(i ? SRC_RESPONSE_BYTE_RECEIVED_FLAG : SRC_RX_BUFFER_FULL_FLAG);
      rv(i ? SRC_RESPONSE_BYTE_RECEIVED_FLAG : SRC_RX_BUFFER_FULL_FLAG);
      apb(1'b0, DATA_OFS, 32'h0, {24'h0, rs[7:0]}, 32'hFFFFFFFF, 1'b0);
      rv(SRC_NONE);
    end
    // two bytes then silence, which must end in an underrun abort
    rs = xs(rs);
    {ta, tb2} = rs[15:0];
    n0 = nbits;
    wr(DATA_OFS, {24'h0, ta});
    `WAITC(nbits > n0)
    `CHK(bus_drive_en, 1'b1)
    rv(SRC_TX_BUFFER_EMPTY_FLAG);
    wr(DATA_OFS, {24'h0, tb2});
    rv(SRC_NONE);
    `WAITC(nbits > n0 + 8)
    rv(SRC_TX_BUFFER_EMPTY_FLAG);
    `WAITC(tx_active === 1'b0)
    `CHK(nbits - n0, 18)
    `CHK(got[17:0], {ta, tb2, 2'b11})
    `CHK(tx_abort, 1'b1)
    pulse(4'h2);
    rv(SRC_INV);
    rv(SRC_ARB);
    rv(SRC_TX_BUFFER_EMPTY_FLAG);
    wr(CTL2_OFS, 32'h1);
    rv(SRC_NONE);
    // single byte closed with crc and end of data
    n0 = nbits;
    nc0 = nclose;
    wr(DATA_OFS, {24'h0, tb2});
    `WAITC(nbits > n0)
    wr(CTL2_OFS, 32'h3);
    `WAITC(tx_active === 1'b0)
    `CHK(tx_abort, 1'b0)
    repeat (3) @(posedge pclk);
    `CHK(nbits - n0, 8)
    `CHK(nclose - nc0, 2)
    rv(SRC_NONE);
    wr(CTL1_OFS, 32'h1);
    cpu_wait <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK(bus_drive_en, 1'b0)
    `CHK(clocks_run, 1'b1)
    rxb(rs[23:16], 1'b0);
    pulse(4'h1);
    `CHK(irq_request, 1'b1)
    cpu_wait <= 1'b0;
    rv(SRC_WAKE);
    rv(SRC_RX_BUFFER_FULL_FLAG);
    apb(1'b0, DATA_OFS, 32'h0, {24'h0, rs[23:16]}, 32'hFFFFFFFF, 1'b0);
    rv(SRC_EOF);
    // stop by instruction, then by wait with the clock-stop bit after end of frame
    for (int i = 0; i < 2; i++) begin
      wr(CTL1_OFS, i ? 32'h2 : 32'h0);
      pulse({3'b000, i[0]});
      cpu_stop <= !i[0];
      cpu_wait <= i[0];
      repeat (3) @(posedge pclk);
      `CHK(clocks_run, 1'b0)
      `CHK(rx_guaranteed, i[0])
      rxs(rs[31:24], 1'b0);
      `WAITC(nmi_request === 1'b1)
      `CHK(nmi_request, 1'b1)
      cpu_stop <= 1'b0;
      cpu_wait <= 1'b0;
      `WAITC(clocks_run === 1'b1)
      `CHK(wk > SETTLE_CYC - 4 && wk < SETTLE_CYC + 4, 1'b1)
      rv(SRC_WAKE);
    end
    tally_and_finish();
  end
endmodule : link_vec_tb
